// ### dv/pin_board.sv
// board model for the extended port pins: pull-ups and other drivers
`timescale 1ns/10ps
`default_nettype none
module pin_board (
  input wire logic [7:0] ext_port_out,
  input wire logic [7:0] ext_port_oe,
  input wire logic [7:0] board_low,
  output logic [7:0] ext_port_in
);
  // ==========================================
  // wire resolution
  // released pins float up through the board pull-ups
  // another driver on the board may only ever pull low, so a pin set up as input
  // with latch and drive bits at one reads that driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_port_oe[i] && !ext_port_out[i]) ext_port_in[i] = 1'b0;
      else if (ext_port_oe[i]) ext_port_in[i] = !board_low[i];
      else ext_port_in[i] = !board_low[i];
    end
  end
endmodule // pin_board
`default_nettype wire

// ### dv/testbench.sv
// register and pin level tests of the extended-address port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [12:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, ext_addr_bus = '0, analog_port_in = '0, board_low = '0;
  logic [7:0] reg_rdata, ext_port_in, ext_port_out, ext_port_oe, d;
  int err_total = 0, num_checks = 0;
  extended_address_port u_extended_address_port (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_addr_bus(ext_addr_bus), .ext_port_in(ext_port_in), .ext_port_out(ext_port_out),
    .ext_port_oe(ext_port_oe), .analog_port_in(analog_port_in));
  pin_board u_pin_board (.ext_port_out(ext_port_out), .ext_port_oe(ext_port_oe),
    .board_low(board_low), .ext_port_in(ext_port_in));
  initial begin
    forever #10 clock = ~clock;
  end
  // ==========================================
  // bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // synchroniser lag is two cycles; four leaves margin, then sample off the edge
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    settle();
    rd(ext_port_pkg::ext_port_function_select_addr, d);
    chk(d, ext_port_pkg::function_select_reset);
    rd(ext_port_pkg::ext_port_drive_type_addr, d);
    chk(d, 8'hff);
    rd(ext_port_pkg::ext_port_output_latch_addr, d);
    chk(d, 8'h00);
    // after reset every pin is open-drain with a low latch, so the port pulls all pins low
    chk(ext_port_oe, 8'hff);
    chk(ext_port_out, 8'h00);
    rd(ext_port_pkg::ext_port_pin_level_addr, d);
    chk(d, 8'h00);
    $display("test reset values done");
    // input setup: latch and drive bits at one release every pin
    wr(ext_port_pkg::ext_port_output_latch_addr, 8'hff);
    wr(ext_port_pkg::ext_port_drive_type_addr, 8'hff);
    @(posedge clock);
    board_low <= 8'h5a;
    settle();
    chk(ext_port_oe, 8'h00);
    rd(ext_port_pkg::ext_port_pin_level_addr, d);
    chk(d, 8'ha5);
    rd(ext_port_pkg::ext_port_output_latch_addr, d);
    chk(d, 8'hff);
    $display("test input pins done");
    @(posedge clock);
    board_low <= 8'h00;
    wr(ext_port_pkg::ext_port_drive_type_addr, 8'h00);
    wr(ext_port_pkg::ext_port_output_latch_addr, 8'h3c);
    settle();
    chk(ext_port_oe, 8'hff);
    chk(ext_port_out, 8'h3c);
    rd(ext_port_pkg::ext_port_pin_level_addr, d);
    chk(d, 8'h3c);
    $display("test push-pull done");
    @(posedge clock);
    ext_addr_bus <= 8'ha5;
    wr(ext_port_pkg::ext_port_function_select_addr, 8'h0f);
    settle();
    chk(ext_port_out, 8'h35);
    chk(ext_port_oe, 8'hff);
    rd(ext_port_pkg::ext_port_function_select_addr, d);
    chk(d, 8'h0f);
    rd(ext_port_pkg::ext_port_pin_level_addr, d);
    chk(d, 8'h35);
    // address pins stay driven although their drive bits ask for open-drain
    wr(ext_port_pkg::ext_port_drive_type_addr, 8'hff);
    wr(ext_port_pkg::ext_port_output_latch_addr, 8'hff);
    settle();
    chk(ext_port_oe, 8'h0f);
    chk(ext_port_out, 8'hf5);
    @(posedge clock);
    ext_addr_bus <= 8'h5a;
    settle();
    chk(ext_port_out, 8'hfa);
    $display("test address mode done");
    @(posedge clock);
    analog_port_in <= 8'hc3;
    settle();
    rd(ext_port_pkg::analog_port_pin_level_addr, d);
    chk(d, 8'hc3);
    @(posedge clock);
    #1 chk(reg_rdata, ext_port_pkg::unmapped_read_value);
    rd(13'h0000, d);
    chk(d, ext_port_pkg::unmapped_read_value);
    $display("test analog and read data done");
    @(posedge clock);
    clk_en <= 1'b0;
    wr(ext_port_pkg::ext_port_output_latch_addr, 8'h00);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(ext_port_pkg::ext_port_output_latch_addr, d);
    chk(d, 8'hff);
    $display("test clock enable done");
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(ext_port_pkg::ext_port_function_select_addr, d);
    chk(d, ext_port_pkg::function_select_reset);
    rd(ext_port_pkg::ext_port_drive_type_addr, d);
    chk(d, 8'hff);
    rd(ext_port_pkg::ext_port_output_latch_addr, d);
    chk(d, 8'h00);
    $display("test second reset done");
    stop_test();
  end
  // a hung run counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end
endmodule // testbench
`default_nettype wire

// ### rtl/ext_port_pkg.sv
// constants for the extended-address port and the analog input port registers
package ext_port_pkg;
  localparam int unsigned addr_width = 13;
  localparam int unsigned port_width = 8;
  localparam int unsigned narrow_width = 4;
  localparam logic [12:0] analog_port_pin_level_addr = 13'h1fda;
  localparam logic [12:0] ext_port_function_select_addr = 13'h1fe1;
  localparam logic [12:0] ext_port_drive_type_addr = 13'h1fe3;
  localparam logic [12:0] ext_port_output_latch_addr = 13'h1fe5;
  localparam logic [12:0] ext_port_pin_level_addr = 13'h1fe7;
  localparam logic [7:0] function_select_reset = 8'h00;
  localparam logic [7:0] drive_type_reset = 8'hff;
  localparam logic [7:0] output_latch_reset = 8'h00;
  localparam logic [7:0] unmapped_read_value = 8'h00;
endpackage : ext_port_pkg

// ### rtl/extended_address_port.sv
// extended-address port and analog input port register block
`timescale 1ns/10ps
`default_nettype none
module extended_address_port #(
  parameter int unsigned PINS = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] ext_addr_bus,
  input wire logic [7:0] ext_port_in,
  output logic [7:0] ext_port_out,
  output logic [7:0] ext_port_oe,
  input wire logic [7:0] analog_port_in
);
  // ===========================================================
  // elaboration check
  if (PINS != ext_port_pkg::port_width && PINS != ext_port_pkg::narrow_width) begin : g_bad_pins
    $error("PINS must be 8 or 4");
  end

  // pins above PINS are absent on the smaller package
  localparam logic [7:0] pin_mask = (PINS == ext_port_pkg::port_width) ? 8'hff : 8'h0f;

  // ===========================================================
  // state
  typedef struct packed {
    logic [7:0] function_select;
    logic [7:0] drive_type;
    logic [7:0] output_latch;
    logic [7:0] rdata;
  } port_state_t;
  port_state_t state_r;
  port_state_t state_nxt;

  logic [7:0] ext_level;
  logic [7:0] analog_level;

  // ===========================================================
  // pin synchronisers
  // pins are asynchronous to clock; nothing reads them before the second flop
  pin_sync #(.WIDTH(8)) u_ext_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in(ext_port_in),
    .sync_out(ext_level)
  );

  pin_sync #(.WIDTH(8)) u_analog_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in(analog_port_in),
    .sync_out(analog_level)
  );

  // ===========================================================
  // register access
  always_comb begin
    state_nxt = state_r;
    if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          ext_port_pkg::ext_port_function_select_addr: state_nxt.function_select = reg_wdata & pin_mask;
          ext_port_pkg::ext_port_drive_type_addr: state_nxt.drive_type = reg_wdata | ~pin_mask;
          ext_port_pkg::ext_port_output_latch_addr: state_nxt.output_latch = reg_wdata & pin_mask;
          default: state_nxt.rdata = state_r.rdata;
        endcase
      end
      // read data lives only in the cycle after the strobe
      state_nxt.rdata = ext_port_pkg::unmapped_read_value;
      if (reg_rd) begin
        case (reg_addr)
          ext_port_pkg::analog_port_pin_level_addr: state_nxt.rdata = analog_level;
          ext_port_pkg::ext_port_function_select_addr: state_nxt.rdata = state_r.function_select;
          ext_port_pkg::ext_port_drive_type_addr: state_nxt.rdata = state_r.drive_type;
          ext_port_pkg::ext_port_output_latch_addr: state_nxt.rdata = state_r.output_latch;
          ext_port_pkg::ext_port_pin_level_addr: state_nxt.rdata = ext_level & pin_mask;
          default: state_nxt.rdata = ext_port_pkg::unmapped_read_value;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r.function_select <= ext_port_pkg::function_select_reset;
      state_r.drive_type <= ext_port_pkg::drive_type_reset;
      state_r.output_latch <= ext_port_pkg::output_latch_reset;
      state_r.rdata <= ext_port_pkg::unmapped_read_value;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;

  // ===========================================================
  // pin drivers
  // address mode drives push-pull regardless of drive type, as the bus needs strong edges
  logic [7:0] drive_val;
  logic [7:0] drive_en;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (state_r.function_select[i]) begin
        drive_val[i] = ext_addr_bus[i];
        drive_en[i] = 1'b1;
      end else begin
        drive_val[i] = state_r.output_latch[i];
        // open-drain only pulls low; a latch of one leaves the pin free for input
        drive_en[i] = !state_r.drive_type[i] || !state_r.output_latch[i];
      end
    end
  end

  assign ext_port_out = drive_val & pin_mask;
  assign ext_port_oe = drive_en & pin_mask;

  // ===========================================================
  // assertions
  property p_latch_reset;
    @(posedge clock) $rose(rst_b) |-> (state_r.output_latch == 8'h00 && state_r.drive_type == 8'hff);
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("reset values wrong");

  property p_drive_write;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == ext_port_pkg::ext_port_drive_type_addr)
      |=> state_r.drive_type == ($past(reg_wdata) | ~pin_mask);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive type write lost");

  property p_addr_mode;
    @(posedge clock) disable iff (!rst_b)
      (state_r.function_select[0]) |-> (ext_port_oe[0] && ext_port_out[0] == ext_addr_bus[0]);
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("address mode not driven");

  property p_pushpull;
    @(posedge clock) disable iff (!rst_b)
      (!state_r.function_select[0] && !state_r.drive_type[0]) |-> (ext_port_oe[0] && ext_port_out[0] == state_r.output_latch[0]);
  endproperty
  a_pushpull: assert property (p_pushpull) else $error("push-pull output wrong");

  property p_open_drain_release;
    @(posedge clock) disable iff (!rst_b)
      (!state_r.function_select[1] && state_r.drive_type[1] && state_r.output_latch[1]) |-> !ext_port_oe[1];
  endproperty
  a_open_drain_release: assert property (p_open_drain_release) else $error("open drain drives high");

  property p_latch_write;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == ext_port_pkg::ext_port_output_latch_addr)
      ##1 (!state_r.function_select[2] && !state_r.drive_type[2])
      |-> ext_port_out[2] == $past(reg_wdata[2]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not driven");

  property p_pin_read;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_rd && reg_addr == ext_port_pkg::ext_port_pin_level_addr)
      |=> reg_rdata == ($past(ext_level) & pin_mask);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

  property p_read_one_cycle;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data lingers");

  property p_upper_masked;
    @(posedge clock) disable iff (!rst_b)
      ((ext_port_oe | ext_port_out) & ~pin_mask) == 8'h00;
  endproperty
  a_upper_masked: assert property (p_upper_masked) else $error("absent pins driven");

  property p_function_write;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == ext_port_pkg::ext_port_function_select_addr)
      |=> state_r.function_select == ($past(reg_wdata) & pin_mask);
  endproperty
  a_function_write: assert property (p_function_write) else $error("function select write lost");

  property p_latch_store;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == ext_port_pkg::ext_port_output_latch_addr)
      |=> state_r.output_latch == ($past(reg_wdata) & pin_mask);
  endproperty
  a_latch_store: assert property (p_latch_store) else $error("output latch write lost");

  property p_analog_read;
    @(posedge clock) disable iff (!rst_b)
      (clk_en && reg_rd && reg_addr == ext_port_pkg::analog_port_pin_level_addr)
      |=> reg_rdata == $past(analog_level);
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog level read wrong");

  // a frozen clock enable must hold every register, the latch included
  property p_freeze;
    @(posedge clock) disable iff (!rst_b)
      !clk_en |=> state_r == $past(state_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  c_addr_mode: cover property (@(posedge clock) disable iff (!rst_b) state_r.function_select != 8'h00);
  c_pushpull: cover property (@(posedge clock) disable iff (!rst_b) state_r.drive_type != 8'hff);
  c_freeze: cover property (@(posedge clock) disable iff (!rst_b) !clk_en && reg_wr);
  c_pin_read: cover property (@(posedge clock) disable iff (!rst_b)
    reg_rd && reg_addr == ext_port_pkg::ext_port_pin_level_addr);
endmodule // extended_address_port
`default_nettype wire

// ### rtl/pin_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;
  sync_state_t state_r;
  sync_state_t state_nxt;

  // first stage feeds only the second stage
  always_comb begin
    state_nxt = state_r;
    if (clk_en) begin
      state_nxt.meta = async_in;
      state_nxt.stable = state_r.meta;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;
endmodule // pin_sync
`default_nettype wire
